// ---- hw/mie_core.sv ----
// How it works
// RL1: Register sums store result, set ZCNVH, one clock
// RL2: Differences store result, set ZCNVH, one clock
// RL3: Word immediate ops on pair, ZCNVS, two clocks
// RL4: AND OR XOR set only ZNV, one clock
// RL5: Mask clear ANDs with inverted constant
// RL6: Test ANDs register with itself, sets ZNV
// RL7: Indirect jump loads PC from Z, two clocks
// RL8: Indirect call pushes return, loads Z, three clocks
// RL9: Equal compare skips next, one to three clocks
// RL10: Immediate compare sets flags without storing
// RL11: Register bit skip on level, one to three
// RL12: Io bit skip on level, one to three
// RL13: Flag branch adds offset plus one, 1/2
// RL14: Signed branch taken when N xor V zero
// RL15: Half-carry branch taken when H set
// RL16: Interrupt branch taken when I set
// RL17: Io bit set/clear, no flags, two clocks
// RL18: Bit ops only for io locations 0..31
// RL19: Bit ops touch only the addressed bit
// RL20: Some io flags clear by writing one
// RL21: Rotate left through carry, ZCNV, one clock
// RL22: Rotate right through carry, ZCNV, one clock
// RL23: Software writes reserved bits as zero
// RL24: Unlisted flags keep their previous values
`include "mie_defines.svh"
module mie_core (
   input  wire logic                 CLK_SYS,
   input  wire logic                 RST,
   input  wire mie_pkg::mie_instr_t  INSTR,
   input  wire logic [7:0]           IO_RDATA,
   output logic [15:0]               PC,
   output logic [7:0]                STATUS,
   output logic [10:0]               STACK_PTR,
   output mie_pkg::mie_stack_t       STACK,
   output mie_pkg::mie_io_bit_t      IO_BIT,
   output mie_pkg::mie_wb_t          WB
);
   ////////////////////////////////////////////////////////////////////
   // Arithmetic helpers
   function automatic mie_pkg::mie_alu_t mie_add8(
      input logic [7:0] x, input logic [7:0] y, input logic ci);
      mie_pkg::mie_alu_t o;
      logic [8:0]        s;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      o.res = s[7:0];
      o.c = s[8];
      o.h = (x[3] & y[3]) | (y[3] & ~s[3]) | (~s[3] & x[3]);
      o.v = (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]);
      return o;
   endfunction

   // Borrow comes out in bit 8 of the wrapped difference
   function automatic mie_pkg::mie_alu_t mie_sub8(
      input logic [7:0] x, input logic [7:0] y, input logic ci);
      mie_pkg::mie_alu_t o;
      logic [8:0]        s;
      s = {1'b0, x} - {1'b0, y} - {8'h00, ci};
      o.res = s[7:0];
      o.c = s[8];
      o.h = (~x[3] & y[3]) | (y[3] & s[3]) | (s[3] & ~x[3]);
      o.v = (x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7]);
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State
   logic [7:0]                regs [32];      // Working registers
   logic [7:0]                next_regs [32];
   mie_pkg::mie_state_t       st;             // Sequencer state
   mie_pkg::mie_state_t       next_st;
   logic [1:0]                wait_left;      // Extra cycles left
   logic [1:0]                next_wait;
   logic                      push_hi;        // High return byte due
   logic                      next_push;
   logic [7:0]                ret_hi;         // Held high return byte
   logic [7:0]                next_ret_hi;
   logic [15:0]               next_pc;
   logic [7:0]                next_core_status_flags;
   logic [10:0]               next_sp;
   mie_pkg::mie_stack_t       next_stack;
   mie_pkg::mie_io_bit_t      next_io;
   mie_pkg::mie_wb_t          next_wb;

   // Operand views
   logic [7:0]  a_val;                        // Destination operand
   logic [7:0]  b_val;                        // Source operand
   logic [15:0] z_val;                        // Z pointer pair
   logic [15:0] w_val;                        // Word pair operand
   logic        io_ok;                        // Bit-addressable io
   logic        run;
   assign a_val = regs[INSTR.dst];
   assign b_val = regs[INSTR.src];
   assign z_val = {regs[31], regs[30]};
   assign w_val = {regs[{INSTR.dst[4:1], 1'b1}],
                   regs[{INSTR.dst[4:1], 1'b0}]};
   assign io_ok = INSTR.imm[5:0] <= `MIE_BIT_IO_LIMIT; // RL18
   assign run   = st == mie_pkg::ST_RUN;

   ////////////////////////////////////////////////////////////////////
   // Next-state computation
   always_comb begin
      mie_pkg::mie_alu_t alu;
      logic [7:0]        res;
      logic [16:0]       ws;
      logic              wr;
      logic              arith;
      logic              lgc;
      logic              skip;
      logic              jump;
      logic [15:0]       ret;
      alu         = '0;
      res         = a_val;
      ws          = '0;
      wr          = 1'b0;
      arith       = 1'b0;
      lgc         = 1'b0;
      skip        = 1'b0;
      jump        = 1'b0;
      ret         = PC + 16'h0001;
      next_regs   = regs;
      next_st     = st;
      next_wait   = wait_left;
      next_push   = push_hi;
      next_ret_hi = ret_hi;
      next_pc     = PC;
      next_core_status_flags   = STATUS;                   // RL24
      next_sp     = STACK_PTR;
      next_stack  = '0;
      next_io     = '0;
      next_wb     = '0;
      case (st)
         mie_pkg::ST_WAIT: begin
            // Second byte of a call return goes out here
            if (push_hi) begin
               next_stack = '{we: 1'b1, addr: STACK_PTR, data: ret_hi}; // RL8
               next_sp    = STACK_PTR - 11'h001;
               next_push  = 1'b0;
            end
            if (wait_left == 2'h0) begin
               next_st = mie_pkg::ST_RUN;
            end else begin
               next_wait = wait_left - 2'h1;
            end
         end
         mie_pkg::ST_SKIP: begin
            // Skipped word on INSTR; a long one costs one more clock
            if (INSTR.two_word) begin
               next_pc   = PC + 16'h0002;     // RL9
               next_st   = mie_pkg::ST_WAIT;
               next_wait = `MIE_WAIT_TWO;
            end else begin
               next_pc = PC + 16'h0001;
               next_st = mie_pkg::ST_RUN;
            end
         end
         mie_pkg::ST_RUN: begin
            next_pc = PC + (INSTR.two_word ? 16'h0002 : 16'h0001);
            case (INSTR.op)
               mie_pkg::OP_SUM, mie_pkg::OP_SUM_CARRY: begin
                  alu = mie_add8(a_val, b_val, // RL1
                     INSTR.op == mie_pkg::OP_SUM_CARRY &&
                     STATUS[`MIE_FLAG_C]);
                  arith = 1'b1;
                  wr    = 1'b1;
               end
               mie_pkg::OP_DIFF, mie_pkg::OP_DIFFERENCE_WITH_BORROW: begin
                  alu = mie_sub8(a_val, b_val, // RL2
                     INSTR.op == mie_pkg::OP_DIFFERENCE_WITH_BORROW &&
                     STATUS[`MIE_FLAG_C]);
                  arith = 1'b1;
                  wr    = 1'b1;
               end
               mie_pkg::OP_IMMEDIATE_DIFFERENCE,
               mie_pkg::OP_IMMEDIATE_DIFFERENCE_BORROW: begin
                  alu = mie_sub8(a_val, INSTR.imm, // RL2
                     INSTR.op == mie_pkg::OP_IMMEDIATE_DIFFERENCE_BORROW &&
                     STATUS[`MIE_FLAG_C]);
                  arith = 1'b1;
                  wr    = 1'b1;
               end
               mie_pkg::OP_COMPARE_IMMEDIATE: begin
                  // Flags only, the register is left alone
                  alu   = mie_sub8(a_val, INSTR.imm, 1'b0); // RL10
                  arith = 1'b1;
               end
               mie_pkg::OP_BITWISE_AND_REGS: begin
                  res = a_val & b_val;        // RL4
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_BITWISE_AND_CONSTANT: begin
                  res = a_val & INSTR.imm;    // RL4
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_BITWISE_OR_REGS: begin
                  res = a_val | b_val;        // RL4
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_BITWISE_OR_CONSTANT: begin
                  res = a_val | INSTR.imm;    // RL4
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_BITWISE_XOR_REGS: begin
                  res = a_val ^ b_val;        // RL4
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_CLEAR_BITS_BY_MASK: begin
                  res = a_val & (8'hFF - INSTR.imm); // RL5
                  lgc = 1'b1;
                  wr  = 1'b1;
               end
               mie_pkg::OP_TEST_ZERO_MINUS: begin
                  // Result equals the operand, so no write is needed
                  res = a_val & a_val;        // RL6
                  lgc = 1'b1;
               end
               mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
                  res = {a_val[6:0], STATUS[`MIE_FLAG_C]}; // RL21
                  next_core_status_flags[`MIE_FLAG_C] = a_val[7];
                  next_core_status_flags[`MIE_FLAG_V] = res[7] ^ a_val[7];
                  next_core_status_flags[`MIE_FLAG_N] = res[7];
                  next_core_status_flags[`MIE_FLAG_Z] = res == 8'h00;
                  wr = 1'b1;
               end
               mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                  res = {STATUS[`MIE_FLAG_C], a_val[7:1]}; // RL22
                  next_core_status_flags[`MIE_FLAG_C] = a_val[0];
                  next_core_status_flags[`MIE_FLAG_V] = res[7] ^ a_val[0];
                  next_core_status_flags[`MIE_FLAG_N] = res[7];
                  next_core_status_flags[`MIE_FLAG_Z] = res == 8'h00;
                  wr = 1'b1;
               end
               mie_pkg::OP_WORD_IMMEDIATE_SUM,
               mie_pkg::OP_WORD_IMMEDIATE_DIFFERENCE: begin
                  // Whole pair is done at once; second clock is a wait
                  if (INSTR.op == mie_pkg::OP_WORD_IMMEDIATE_SUM) begin
                     ws = {1'b0, w_val} + {11'h000, INSTR.imm[5:0]};
                     next_core_status_flags[`MIE_FLAG_V] = ~w_val[15] & ws[15];
                     next_core_status_flags[`MIE_FLAG_C] = ~ws[15] & w_val[15];
                  end else begin
                     ws = {1'b0, w_val} - {11'h000, INSTR.imm[5:0]};
                     next_core_status_flags[`MIE_FLAG_V] = w_val[15] & ~ws[15];
                     next_core_status_flags[`MIE_FLAG_C] = ws[15] & ~w_val[15];
                  end
                  next_core_status_flags[`MIE_FLAG_N] = ws[15];   // RL3
                  next_core_status_flags[`MIE_FLAG_S] = ws[15] ^
                                           next_core_status_flags[`MIE_FLAG_V];
                  next_core_status_flags[`MIE_FLAG_Z] = ws[15:0] == 16'h0000;
                  next_regs[{INSTR.dst[4:1], 1'b0}] = ws[7:0];
                  next_regs[{INSTR.dst[4:1], 1'b1}] = ws[15:8];
                  next_wb   = '{we: 1'b1, addr: {INSTR.dst[4:1], 1'b1},
                                data: ws[15:8]};
                  next_st   = mie_pkg::ST_WAIT;
                  next_wait = `MIE_WAIT_TWO;
               end
               mie_pkg::OP_INDIRECT_JUMP: begin
                  next_pc   = z_val;          // RL7
                  next_st   = mie_pkg::ST_WAIT;
                  next_wait = `MIE_WAIT_TWO;
               end
               mie_pkg::OP_INDIRECT_SUBROUTINE_JUMP: begin
                  // Low return byte now, high byte in the next clock
                  next_pc     = z_val;        // RL8
                  next_stack  = '{we: 1'b1, addr: STACK_PTR, data: ret[7:0]};
                  next_sp     = STACK_PTR - 11'h001;
                  next_ret_hi = ret[15:8];
                  next_push   = 1'b1;
                  next_st     = mie_pkg::ST_WAIT;
                  next_wait   = `MIE_WAIT_THREE;
               end
               mie_pkg::OP_COMPARE_SKIP_EQUAL:
                  skip = a_val == b_val;      // RL9
               mie_pkg::OP_SKIP_REG_BIT_CLEAR:
                  skip = !b_val[INSTR.sel];   // RL11
               mie_pkg::OP_SKIP_REG_BIT_SET:
                  skip = b_val[INSTR.sel];    // RL11
               mie_pkg::OP_SKIP_IO_BIT_CLEAR:
                  skip = io_ok && !IO_RDATA[INSTR.sel]; // RL12
               mie_pkg::OP_SKIP_IO_BIT_SET:
                  skip = io_ok && IO_RDATA[INSTR.sel];  // RL12
               // Flag index 5 is half carry, index 7 interrupt enable
               mie_pkg::OP_BRANCH_STATUS_FLAG_SET:
                  jump = STATUS[INSTR.sel];   // RL13 RL15 RL16
               mie_pkg::OP_BRANCH_STATUS_FLAG_CLEAR:
                  jump = !STATUS[INSTR.sel];  // RL13
               mie_pkg::OP_BRANCH_SIGNED_NOT_LESS:
                  jump = !(STATUS[`MIE_FLAG_N] ^ STATUS[`MIE_FLAG_V]); // RL14
               mie_pkg::OP_IO_BIT_SET, mie_pkg::OP_IO_BIT_CLEAR: begin
                  // One-bit strobe, never read-modify-write, so
                  // write-one-clear flags beside it stay untouched
                  if (io_ok) begin            // RL18
                     next_io = '{set: INSTR.op == mie_pkg::OP_IO_BIT_SET,
                                 clr: INSTR.op == mie_pkg::OP_IO_BIT_CLEAR,
                                 addr: INSTR.imm[4:0],
                                 sel: INSTR.sel}; // RL17 RL19 RL20
                     next_st   = mie_pkg::ST_WAIT;
                     next_wait = `MIE_WAIT_TWO;
                  end
               end
               mie_pkg::OP_LOAD_CONSTANT: begin
                  res = INSTR.imm;
                  wr  = 1'b1;
               end
               mie_pkg::OP_FLAG_SET:
                  next_core_status_flags[INSTR.sel] = 1'b1;
               mie_pkg::OP_FLAG_CLEAR:
                  next_core_status_flags[INSTR.sel] = 1'b0;
               default: ;
            endcase
            // Flag groups for byte results
            if (arith) begin
               res = alu.res;
               next_core_status_flags[`MIE_FLAG_H] = alu.h;
               next_core_status_flags[`MIE_FLAG_C] = alu.c;
               next_core_status_flags[`MIE_FLAG_V] = alu.v;
            end
            if (arith || lgc) begin
               next_core_status_flags[`MIE_FLAG_N] = res[7];
               next_core_status_flags[`MIE_FLAG_Z] = res == 8'h00;
            end
            if (lgc) begin
               next_core_status_flags[`MIE_FLAG_V] = 1'b0; // RL4
            end
            if (wr) begin
               next_regs[INSTR.dst] = res;
               next_wb = '{we: 1'b1, addr: INSTR.dst, data: res};
            end
            if (skip) begin
               next_st = mie_pkg::ST_SKIP;
            end
            if (jump) begin
               next_pc = PC + {{9{INSTR.imm[6]}}, INSTR.imm[6:0]} +
                         16'h0001;
               next_st   = mie_pkg::ST_WAIT;
               next_wait = `MIE_WAIT_TWO;
            end
         end
         default: next_st = mie_pkg::ST_RUN;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         for (int i = 0; i < 32; i++) begin
            regs[i] <= 8'h00;
         end
         st        <= mie_pkg::ST_RUN;
         wait_left <= 2'h0;
         push_hi   <= 1'b0;
         ret_hi    <= 8'h00;
         PC        <= `MIE_PC_RESET;
         STATUS    <= `MIE_CORE_STATUS_FLAGS_RESET;
         STACK_PTR <= `MIE_SP_RESET;
         STACK     <= '0;
         IO_BIT    <= '0;
         WB        <= '0;
      end else begin
         regs      <= next_regs;
         st        <= next_st;
         wait_left <= next_wait;
         push_hi   <= next_push;
         ret_hi    <= next_ret_hi;
         PC        <= next_pc;
         STATUS    <= next_core_status_flags;
         STACK_PTR <= next_sp;
         STACK     <= next_stack;
         IO_BIT    <= next_io;
         WB        <= next_wb;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   chk_sum_result: assert property ( // RL1
      run && INSTR.op == mie_pkg::OP_SUM |=>
      WB.we && WB.data == $past(a_val + b_val) && run)
      else $error("register sum wrong or slow");
   chk_diff_borrow: assert property ( // RL2
      run && INSTR.op == mie_pkg::OP_DIFF |=>
      STATUS[`MIE_FLAG_C] == $past(a_val < b_val))
      else $error("difference borrow wrong");
   chk_word_clocks: assert property ( // RL3
      run && INSTR.op == mie_pkg::OP_WORD_IMMEDIATE_SUM |=>
      !run ##1 run)
      else $error("word op not two clocks");
   chk_logic_flags: assert property ( // RL4
      run && INSTR.op == mie_pkg::OP_BITWISE_XOR_REGS |=>
      !STATUS[`MIE_FLAG_V] &&
      STATUS[`MIE_FLAG_C] == $past(STATUS[`MIE_FLAG_C]))
      else $error("logic op flags wrong");
   chk_flag_keep: assert property ( // RL24
      run && INSTR.op == mie_pkg::OP_SUM_CARRY |=>
      STATUS[7:6] == $past(STATUS[7:6]) && STATUS[4] == $past(STATUS[4]))
      else $error("unlisted flag changed");
   chk_jump_target: assert property ( // RL7
      run && INSTR.op == mie_pkg::OP_INDIRECT_JUMP |=>
      PC == $past(z_val) && !run ##1 run)
      else $error("indirect jump wrong");
   chk_call_push: assert property ( // RL8
      run && INSTR.op == mie_pkg::OP_INDIRECT_SUBROUTINE_JUMP |=>
      STACK.we [*2] ##1 run)
      else $error("indirect call push wrong");
   chk_signed_branch: assert property ( // RL14
      run && INSTR.op == mie_pkg::OP_BRANCH_SIGNED_NOT_LESS &&
      (STATUS[`MIE_FLAG_N] ^ STATUS[`MIE_FLAG_V]) |=>
      run && PC == $past(PC) + 16'h0001)
      else $error("signed branch taken wrongly");
   chk_io_limit: assert property ( // RL18
      run && INSTR.op == mie_pkg::OP_IO_BIT_SET && !io_ok |=>
      !IO_BIT.set && run)
      else $error("bit op beyond io limit");
   chk_skip_clocks: assert property ( // RL9
      st == mie_pkg::ST_SKIP && INSTR.two_word |=> !run ##1 run)
      else $error("long skip not three clocks");
endmodule

// ---- shared/mie_defines.svh ----
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH
// Status flag bit positions
`define MIE_FLAG_C 0
`define MIE_FLAG_Z 1
`define MIE_FLAG_N 2
`define MIE_FLAG_V 3
`define MIE_FLAG_S 4
`define MIE_FLAG_H 5
`define MIE_FLAG_T 6
`define MIE_FLAG_I 7
// Core register locations in the io map
`define MIE_OFS_STACK_LOW  8'h3D
`define MIE_OFS_STACK_HIGH 8'h3E
`define MIE_OFS_STATUS     8'h3F
// Highest io location reachable by single-bit operations
`define MIE_BIT_IO_LIMIT 6'h1F
// Reset values
`define MIE_PC_RESET   16'h0000
`define MIE_CORE_STATUS_FLAGS_RESET 8'h00
`define MIE_SP_RESET   11'h000
// Wait counter loads after the first clock of a multi-clock op; it waits one clock more than the value
`define MIE_WAIT_TWO   2'h0
`define MIE_WAIT_THREE 2'h1
`endif

// ---- shared/mie_pkg.sv ----
package mie_pkg;
   // Operation codes of the core
   typedef enum logic [5:0] {
      OP_NOP                          = 6'h00,
      OP_SUM                          = 6'h01,
      OP_SUM_CARRY                    = 6'h02,
      OP_DIFF                         = 6'h03,
      OP_IMMEDIATE_DIFFERENCE         = 6'h04,
      OP_DIFFERENCE_WITH_BORROW       = 6'h05,
      OP_IMMEDIATE_DIFFERENCE_BORROW  = 6'h06,
      OP_BITWISE_AND_REGS             = 6'h07,
      OP_BITWISE_AND_CONSTANT         = 6'h08,
      OP_BITWISE_OR_REGS              = 6'h09,
      OP_BITWISE_OR_CONSTANT          = 6'h0A,
      OP_BITWISE_XOR_REGS             = 6'h0B,
      OP_CLEAR_BITS_BY_MASK           = 6'h0C,
      OP_TEST_ZERO_MINUS              = 6'h0D,
      OP_WORD_IMMEDIATE_SUM           = 6'h0E,
      OP_WORD_IMMEDIATE_DIFFERENCE    = 6'h0F,
      OP_INDIRECT_JUMP                = 6'h10,
      OP_INDIRECT_SUBROUTINE_JUMP     = 6'h11,
      OP_COMPARE_SKIP_EQUAL           = 6'h12,
      OP_COMPARE_IMMEDIATE            = 6'h13,
      OP_SKIP_REG_BIT_CLEAR           = 6'h14,
      OP_SKIP_REG_BIT_SET             = 6'h15,
      OP_SKIP_IO_BIT_CLEAR            = 6'h16,
      OP_SKIP_IO_BIT_SET              = 6'h17,
      OP_BRANCH_STATUS_FLAG_SET       = 6'h18,
      OP_BRANCH_STATUS_FLAG_CLEAR     = 6'h19,
      OP_BRANCH_SIGNED_NOT_LESS       = 6'h1A,
      OP_IO_BIT_SET                   = 6'h1B,
      OP_IO_BIT_CLEAR                 = 6'h1C,
      OP_ROTATE_LEFT_THROUGH_CARRY    = 6'h1D,
      OP_ROTATE_RIGHT_THROUGH_CARRY   = 6'h1E,
      OP_LOAD_CONSTANT                = 6'h1F,
      OP_FLAG_SET                     = 6'h20,
      OP_FLAG_CLEAR                   = 6'h21
   } mie_op_t;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_RUN  = 2'h0,
      ST_WAIT = 2'h1,
      ST_SKIP = 2'h2
   } mie_state_t;
   // Instruction as presented by program memory
   typedef struct packed {
      logic       two_word;
      mie_op_t    op;
      logic [4:0] dst;
      logic [4:0] src;
      logic [7:0] imm;
      logic [2:0] sel;
   } mie_instr_t;
   // Stack write strobe
   typedef struct packed {
      logic        we;
      logic [10:0] addr;
      logic [7:0]  data;
   } mie_stack_t;
   // Single-bit io request
   typedef struct packed {
      logic       set;
      logic       clr;
      logic [4:0] addr;
      logic [2:0] sel;
   } mie_io_bit_t;
   // Register write-back report
   typedef struct packed {
      logic       we;
      logic [4:0] addr;
      logic [7:0] data;
   } mie_wb_t;
   // Byte adder or subtractor result
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       h;
      logic       v;
   } mie_alu_t;
endpackage

// ---- test/test_mie_core.sv ----
module test_mie_core;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 CLK_SYS   = 1'b0; // 100 MHz system clock
   logic                 RST       = 1'b1; // Held high at start
   mie_pkg::mie_instr_t  INSTR     = '0;   // Idle word is a no-op
   logic [7:0]           IO_RDATA  = 8'h08; // Only bit 3 set
   logic [15:0]          PC;
   logic [7:0]           STATUS;
   logic [10:0]          STACK_PTR;
   mie_pkg::mie_stack_t  STACK;
   mie_pkg::mie_io_bit_t IO_BIT;
   mie_pkg::mie_wb_t     WB;
   int                   n_errors  = 0;
   int                   tests_run = 0;
   ////////////////////////////////////////
   // Clock toggles every half period
   always #5 CLK_SYS = ~CLK_SYS;
   mie_core dut (
      .CLK_SYS   (CLK_SYS),
      .RST       (RST),
      .INSTR     (INSTR),
      .IO_RDATA  (IO_RDATA),
      .PC        (PC),
      .STATUS    (STATUS),
      .STACK_PTR (STACK_PTR),
      .STACK     (STACK),
      .IO_BIT    (IO_BIT),
      .WB        (WB)
   );
   // Case equality so an unknown never matches
   task automatic chk(input string w, input logic [19:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", w, exp, seen);
      end
   endtask
   // One op, then no-ops for its extra clocks; the leading edge runs a
   // no-op too, so every call costs one extra PC step in run state
   task automatic run(input mie_pkg::mie_op_t op, input logic [4:0] d, s,
                      input logic [7:0] k, input int n);
      @(posedge CLK_SYS);
      INSTR <= '{1'b0, op, d, s, k, d[2:0]};
      @(posedge CLK_SYS);
      INSTR <= {n > 2, 27'h0};
      repeat (n - 1) begin
         @(posedge CLK_SYS);
         INSTR <= '0;
      end
      #1;
   endtask
   // One edge, then let its updates land
   task automatic tick;
      @(posedge CLK_SYS);
      #1;
   endtask
   task automatic done(input string t);
      $display("test %s done", t);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Main sequence; sel rides on the low bits of dst
   initial begin
      repeat (12) @(posedge CLK_SYS);
      RST <= 1'b0;
      #1;
      chk("pc", PC, 20'h0);
      chk("sr", STATUS, 20'h0);
      chk("sp", STACK_PTR, 20'h0);
      done("reset");
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h10, 5'h00, 8'h0F, 1);
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h11, 5'h00, 8'h01, 1);
      run(mie_pkg::OP_SUM, 5'h10, 5'h11, 8'h00, 1);
      chk("wb", WB, 20'h3010);
      chk("sr", STATUS, 20'h20);
      chk("pc", PC, 20'h6);
      run(mie_pkg::OP_COMPARE_IMMEDIATE, 5'h10, 5'h00, 8'h10, 1);
      chk("we", WB.we, 20'h0);
      chk("sr", STATUS, 20'h02);
      run(mie_pkg::OP_IMMEDIATE_DIFFERENCE, 5'h10, 5'h00, 8'h11, 1);
      chk("wb", WB, 20'h30FF);
      chk("sr", STATUS, 20'h25);
      run(mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, 5'h10, 5'h00, 8'h00, 1);
      chk("sr", STATUS, 20'h25);
      run(mie_pkg::OP_ROTATE_LEFT_THROUGH_CARRY, 5'h11, 5'h00, 8'h00, 1);
      chk("wb", WB, 20'h3103);
      chk("sr", STATUS, 20'h20);
      chk("pc", PC, 20'hE);
      run(mie_pkg::OP_BITWISE_AND_CONSTANT, 5'h10, 5'h00, 8'h00, 1);
      chk("sr", STATUS, 20'h22);
      run(mie_pkg::OP_BITWISE_OR_CONSTANT, 5'h10, 5'h00, 8'h80, 1);
      chk("wb", WB, 20'h3080);
      chk("sr", STATUS, 20'h24);
      run(mie_pkg::OP_CLEAR_BITS_BY_MASK, 5'h10, 5'h00, 8'h80, 1);
      chk("wb", WB, 20'h3000);
      chk("sr", STATUS, 20'h22);
      run(mie_pkg::OP_TEST_ZERO_MINUS, 5'h11, 5'h11, 8'h00, 1);
      chk("sr", STATUS, 20'h20);
      run(mie_pkg::OP_BITWISE_XOR_REGS, 5'h11, 5'h11, 8'h00, 1);
      chk("wb", WB, 20'h3100);
      chk("sr", STATUS, 20'h22);
      done("alu");
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h1E, 5'h00, 8'h34, 1);
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h1F, 5'h00, 8'h12, 1);
      run(mie_pkg::OP_COMPARE_SKIP_EQUAL, 5'h10, 5'h1F, 8'h00, 1);
      chk("pc", PC, 20'h1E);
      run(mie_pkg::OP_COMPARE_SKIP_EQUAL, 5'h11, 5'h11, 8'h00, 2);
      chk("pc", PC, 20'h21);
      run(mie_pkg::OP_COMPARE_SKIP_EQUAL, 5'h11, 5'h11, 8'h00, 3);
      chk("pc", PC, 20'h25);
      run(mie_pkg::OP_SKIP_REG_BIT_SET, 5'h12, 5'h1E, 8'h00, 2);
      chk("pc", PC, 20'h28);
      run(mie_pkg::OP_INDIRECT_JUMP, 5'h00, 5'h00, 8'h00, 2);
      chk("pc", PC, 20'h1234);
      chk("sr", STATUS, 20'h22);
      run(mie_pkg::OP_INDIRECT_SUBROUTINE_JUMP, 5'h00, 5'h00, 8'h00, 1);
      chk("st", STACK, 20'h80036);
      chk("pc", PC, 20'h1234);
      tick();
      chk("st", STACK, 20'hFFF12);
      chk("sp", STACK_PTR, 20'h7FE);
      tick();
      done("flow");
      // Addresses above the bit-reachable range must be refused
      run(mie_pkg::OP_SKIP_IO_BIT_SET, 5'h03, 5'h00, 8'h05, 2);
      chk("pc", PC, 20'h1237);
      run(mie_pkg::OP_SKIP_IO_BIT_SET, 5'h03, 5'h00, 8'h25, 1);
      chk("pc", PC, 20'h1239);
      run(mie_pkg::OP_SKIP_IO_BIT_CLEAR, 5'h03, 5'h00, 8'h05, 1);
      chk("pc", PC, 20'h123B);
      run(mie_pkg::OP_IO_BIT_SET, 5'h03, 5'h00, 8'h05, 1);
      chk("io", IO_BIT, 20'h22B);
      tick();
      chk("io", IO_BIT, 20'h0);
      chk("pc", PC, 20'h123D);
      run(mie_pkg::OP_IO_BIT_CLEAR, 5'h01, 5'h00, 8'h05, 1);
      chk("io", IO_BIT, 20'h129);
      tick();
      run(mie_pkg::OP_IO_BIT_CLEAR, 5'h01, 5'h00, 8'h25, 1);
      chk("io", IO_BIT, 20'h0);
      chk("pc", PC, 20'h1241);
      done("io");
      run(mie_pkg::OP_BRANCH_SIGNED_NOT_LESS, 5'h00, 5'h00, 8'h05, 2);
      chk("pc", PC, 20'h1248);
      run(mie_pkg::OP_BRANCH_STATUS_FLAG_SET, 5'h01, 5'h00, 8'h7E, 2);
      chk("pc", PC, 20'h1248);
      run(mie_pkg::OP_BRANCH_STATUS_FLAG_CLEAR, 5'h01, 5'h00, 8'h05, 1);
      chk("pc", PC, 20'h124A);
      run(mie_pkg::OP_BRANCH_STATUS_FLAG_SET, 5'h05, 5'h00, 8'h02, 2);
      chk("pc", PC, 20'h124E);
      run(mie_pkg::OP_BRANCH_STATUS_FLAG_SET, 5'h07, 5'h00, 8'h05, 1);
      chk("pc", PC, 20'h1250);
      done("branch");
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h18, 5'h00, 8'hFF, 1);
      run(mie_pkg::OP_LOAD_CONSTANT, 5'h19, 5'h00, 8'h00, 1);
      run(mie_pkg::OP_WORD_IMMEDIATE_SUM, 5'h18, 5'h00, 8'h01, 2);
      chk("pc", PC, 20'h1256);
      chk("sr", STATUS, 20'h20);
      run(mie_pkg::OP_COMPARE_IMMEDIATE, 5'h19, 5'h00, 8'h01, 1);
      chk("sr", STATUS, 20'h02);
      run(mie_pkg::OP_WORD_IMMEDIATE_DIFFERENCE, 5'h18, 5'h00, 8'h01, 2);
      chk("pc", PC, 20'h125A);
      chk("sr", STATUS, 20'h00);
      run(mie_pkg::OP_COMPARE_IMMEDIATE, 5'h18, 5'h00, 8'hFF, 1);
      chk("sr", STATUS, 20'h02);
      run(mie_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY, 5'h18, 5'h00, 8'h00, 1);
      chk("wb", WB, 20'h387F);
      chk("sr", STATUS, 20'h09);
      run(mie_pkg::OP_BRANCH_SIGNED_NOT_LESS, 5'h00, 5'h00, 8'h05, 1);
      chk("pc", PC, 20'h1260);
      run(mie_pkg::OP_FLAG_SET, 5'h07, 5'h00, 8'h00, 1);
      run(mie_pkg::OP_BRANCH_STATUS_FLAG_SET, 5'h07, 5'h00, 8'h05, 2);
      chk("pc", PC, 20'h1269);
      run(mie_pkg::OP_IO_BIT_SET, 5'h01, 5'h00, 8'h25, 1);
      chk("io", IO_BIT, 20'h0);
      run(mie_pkg::OP_DIFF, 5'h19, 5'h18, 8'h00, 1);
      done("word");
      final_report();
   end
endmodule
